// ### include/plt_pkg.sv
package plt_pkg;
   // =========================================================
   // control and data pair encodings
   localparam logic [1:0] PLT_CTL_IDLE = 2'h0;
   localparam logic [1:0] PLT_CTL_STATUS = 2'h1; // phy driven
   localparam logic [1:0] PLT_CTL_RECEIVE = 2'h2; // phy driven
   localparam logic [1:0] PLT_CTL_GRANT = 2'h3; // phy driven
   localparam logic [1:0] PLT_CTL_HOLD = 2'h1; // link driven
   localparam logic [1:0] PLT_CTL_LINK_TX = 2'h2; // link driven
   localparam logic [1:0] PLT_SPEED_CODE = 2'h0; // backplane speed code
   localparam logic [1:0] PLT_D_ALL_HIGH = 2'h3;
   localparam logic [1:0] PLT_D_ZERO = 2'h0;

   // =========================================================
   // serial bus rates and transmit bit cell limits
   localparam int PLT_CLK_PERIOD_PS = 50000;
   localparam int PLT_RATE_SLOW_KBPS = 49152;
   localparam int PLT_RATE_FAST_KBPS = 98304;
   localparam int PLT_ARB_CLK_KHZ = 49152;
   localparam int PLT_CELL_FAST_PS = 9440;
   localparam int PLT_CELL_SLOW_PS = 19440;
   // least times round up, never below one cycle
   localparam int PLT_CELL_FAST_CYC = (PLT_CELL_FAST_PS + PLT_CLK_PERIOD_PS - 1)
      / PLT_CLK_PERIOD_PS;
   localparam int PLT_CELL_SLOW_CYC = (PLT_CELL_SLOW_PS + PLT_CLK_PERIOD_PS - 1)
      / PLT_CLK_PERIOD_PS;
   localparam int PLT_GAP_CYC_DEF = 4;
   // decisions skipped after the lines are handed to the link: the
   // registered copies still hold the phy's idle and the empty turnaround
   localparam int PLT_TURN_CYC = 2;
   localparam int PLT_CNT_W = 8;

   // =========================================================
   // states, one-hot
   typedef enum logic [8:0] {
      PLT_IDLE = 9'h001,
      PLT_GRANT = 9'h002,
      PLT_GRANT_IDLE = 9'h004,
      PLT_LINK_OWN = 9'h008,
      PLT_RELEASE = 9'h010,
      PLT_HOLD_WAIT = 9'h020,
      PLT_RX_HEAD = 9'h040,
      PLT_RX_SPEED = 9'h080,
      PLT_RX_DATA = 9'h100
   } plt_state_t;

   // a pin bundle with output enable
   typedef struct packed {
      logic [1:0] o;
      logic [1:0] oe;
   } plt_pair_t;

   // whole state of the block
   typedef struct packed {
      plt_state_t state;
      plt_pair_t ctl;
      plt_pair_t dat;
      logic [1:0] ctl_in_q;
      logic [1:0] d_in_q;
      logic in_packet;
      logic end_hold;
      logic [PLT_CNT_W-1:0] cnt;
      logic [PLT_CNT_W-1:0] tx_cell_cnt;
      logic tx_valid;
      logic [1:0] tx_data;
      logic [1:0] bp_oe;
      logic data_on;
      logic totem;
      logic rx_ready;
   } plt_reg_t;
endpackage

// ### core/plt_phy_link.sv
`timescale 1ns/1ps
module plt_phy_link
   import plt_pkg::*;
#(
   parameter int GAP_CYC = PLT_GAP_CYC_DEF
) (
   // clock, reset, enable
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic CE,
   // link side
   input wire logic LINK_REQUEST_LINE,
   input wire logic [1:0] CONTROL_PAIR_I,
   output logic [1:0] CONTROL_PAIR_O,
   output logic [1:0] CONTROL_PAIR_OE,
   input wire logic [1:0] DATA_PAIR_I,
   output logic [1:0] DATA_PAIR_O,
   output logic [1:0] DATA_PAIR_OE,
   // arbitration and serial receive
   input wire logic ARB_WON,
   input wire logic SPEED_FAST,
   input wire logic RX_START,
   input wire logic RX_VALID,
   input wire logic [1:0] RX_PAIR,
   input wire logic RX_LAST,
   output logic RX_READY,
   // serial transmit
   output logic TX_VALID,
   output logic [1:0] TX_PAIR,
   output logic [1:0] BP_DRIVE_OE,
   output logic DATA_ON,
   output logic DRV_TOTEM
);

   plt_reg_t r_reg;
   plt_reg_t r_next;

   // =========================================================
   // next state
   always_comb begin
      r_next = r_reg;
      // registered copies let decisions lag a cycle safely
      r_next.ctl_in_q = CONTROL_PAIR_I;
      r_next.d_in_q = DATA_PAIR_I;
      r_next.tx_valid = 1'b0;
      r_next.data_on = 1'b0;
      if (r_reg.tx_cell_cnt != '0) begin
         r_next.tx_cell_cnt = r_reg.tx_cell_cnt - 1'b1;
      end
      case (r_reg.state)
         PLT_IDLE: begin
            r_next.ctl = '{o: PLT_CTL_IDLE, oe: 2'h3};
            r_next.dat = '{o: PLT_D_ZERO, oe: 2'h3};
            r_next.totem = 1'b0;
            // an arriving packet beats a pending request
            if (RX_START) begin
               r_next.ctl.o = PLT_CTL_RECEIVE;
               r_next.dat.o = PLT_D_ALL_HIGH;
               r_next.state = PLT_RX_HEAD;
            end else if (LINK_REQUEST_LINE && ARB_WON) begin
               r_next.ctl.o = PLT_CTL_GRANT;
               r_next.state = PLT_GRANT;
            end
         end
         PLT_RX_HEAD: begin
            r_next.dat.o = PLT_SPEED_CODE;
            r_next.totem = 1'b1;
            r_next.state = PLT_RX_SPEED;
         end
         PLT_RX_SPEED: begin
            // speed slot is never part of the forwarded pairs
            if (RX_VALID) begin
               r_next.dat.o = RX_PAIR;
               r_next.state = PLT_RX_DATA;
               if (RX_LAST) begin
                  r_next.state = PLT_IDLE;
               end
            end
         end
         PLT_RX_DATA: begin
            r_next.ctl.o = PLT_CTL_RECEIVE;
            if (RX_VALID) begin
               r_next.dat.o = RX_PAIR;
               if (RX_LAST) begin
                  r_next.state = PLT_IDLE;
               end
            end
         end
         PLT_GRANT: begin
            r_next.ctl.o = PLT_CTL_IDLE;
            r_next.state = PLT_GRANT_IDLE;
         end
         PLT_GRANT_IDLE: begin
            // release the lines; the link picks them up a cycle on
            r_next.ctl.oe = 2'h0;
            r_next.dat.oe = 2'h0;
            r_next.in_packet = 1'b0;
            r_next.end_hold = 1'b0;
            r_next.cnt = PLT_CNT_W'(PLT_TURN_CYC);
            r_next.state = PLT_LINK_OWN;
         end
         PLT_LINK_OWN: begin
            // without this wait our own idle would read as a release
            if (r_reg.cnt != '0) begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end else if (r_reg.ctl_in_q == PLT_CTL_LINK_TX) begin
               // transmit may come with no hold first
               r_next.tx_valid = 1'b1;
               r_next.tx_data = r_reg.d_in_q;
               r_next.totem = 1'b1;
               r_next.in_packet = 1'b1;
               r_next.end_hold = 1'b0;
               r_next.tx_cell_cnt = SPEED_FAST ? PLT_CNT_W'(PLT_CELL_FAST_CYC)
                  : PLT_CNT_W'(PLT_CELL_SLOW_CYC);
            end else if (r_reg.ctl_in_q == PLT_CTL_HOLD) begin
               r_next.data_on = 1'b1;
               if (r_reg.in_packet) begin
                  r_next.end_hold = 1'b1;
                  r_next.in_packet = 1'b0;
               end
            end else if (r_reg.in_packet) begin
               r_next.in_packet = 1'b0; // first idle after packet
               r_next.totem = 1'b0;
            end else if (r_reg.end_hold) begin
               // hold then idle: keep the bus for another packet
               r_next.cnt = PLT_CNT_W'(GAP_CYC);
               r_next.data_on = 1'b1;
               r_next.state = PLT_HOLD_WAIT;
            end else if (r_reg.tx_cell_cnt == '0 && !r_reg.totem) begin
               r_next.state = PLT_RELEASE;
            end
         end
         PLT_HOLD_WAIT: begin
            r_next.data_on = 1'b1;
            r_next.totem = 1'b0;
            if (r_reg.cnt == '0) begin
               r_next.ctl = '{o: PLT_CTL_GRANT, oe: 2'h3};
               r_next.dat = '{o: PLT_D_ZERO, oe: 2'h3};
               r_next.state = PLT_GRANT;
            end else begin
               r_next.cnt = r_reg.cnt - 1'b1;
            end
         end
         PLT_RELEASE: begin
            // lines go back to the phy, driven as idle and zero
            r_next.ctl = '{o: PLT_CTL_IDLE, oe: 2'h3};
            r_next.dat = '{o: PLT_D_ZERO, oe: 2'h3};
            r_next.state = PLT_IDLE;
         end
         default: begin
            r_next.state = PLT_IDLE;
         end
      endcase
      // driven line means 1; totem may also drive released level
      r_next.bp_oe = r_next.tx_data | {2{r_next.totem}};
      r_next.rx_ready = (r_next.state == PLT_RX_SPEED) || (r_next.state == PLT_RX_DATA);
   end

   // =========================================================
   // state register
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         r_reg <= '{state: PLT_IDLE, ctl: '{o: PLT_CTL_IDLE, oe: 2'h0},
                    dat: '{o: PLT_D_ZERO, oe: 2'h0}, default: '0};
      end else if (CE) begin
         r_reg <= r_next;
      end
   end

   // =========================================================
   // outputs straight from flops
   assign CONTROL_PAIR_O = r_reg.ctl.o;
   assign CONTROL_PAIR_OE = r_reg.ctl.oe;
   assign DATA_PAIR_O = r_reg.dat.o;
   assign DATA_PAIR_OE = r_reg.dat.oe;
   assign TX_VALID = r_reg.tx_valid;
   assign TX_PAIR = r_reg.tx_data;
   assign BP_DRIVE_OE = r_reg.bp_oe;
   assign DATA_ON = r_reg.data_on;
   assign DRV_TOTEM = r_reg.totem;
   assign RX_READY = r_reg.rx_ready;

endmodule

// ### verif/plt_link_model.sv
`timescale 1ns/1ps
// ========================================
// behavioural link controller on the phy-link pins
module plt_link_model
   import plt_pkg::*;
(
   // phy drive of the control pair
   input wire logic clk,
   input wire logic [1:0] ctl_o,
   input wire logic [1:0] ctl_oe,
   // link drive, released while own is low
   output logic own = 1'h0,
   output logic [1:0] ctl = 2'h0,
   output logic [1:0] dat = 2'h0
);
   logic [1:0] sent[$];
   // set when a grant never came within the wait limit
   logic hung = 1'h0;
   // grant, spare cycle, optional hold, packet, end code, idle, release
   task automatic own_bus(input int nhold, input int npairs, input bit more);
      for (int n = 0; n < 60 && {ctl_oe, ctl_o} != 4'hf; n++) @(negedge clk);
      if ({ctl_oe, ctl_o} != 4'hf) hung = 1'h1;
      repeat (3) @(negedge clk);
      own = 1'h1;
      if (nhold > 0) begin
         ctl = PLT_CTL_HOLD;
         repeat (nhold) @(negedge clk);
      end
      // zero hold sends straight after the grant
      repeat (npairs) begin
         ctl = PLT_CTL_LINK_TX;
         dat = 2'($urandom);
         sent.push_back(dat);
         @(negedge clk);
      end
      ctl = more ? PLT_CTL_HOLD : PLT_CTL_IDLE;
      @(negedge clk);
      ctl = PLT_CTL_IDLE;
      @(negedge clk);
      own = 1'h0;
   endtask
endmodule

// ### verif/plt_phy_link_asserts.sv
`timescale 1ns/1ps
// ========================================
// pin-level checks of the phy-link handshake
module plt_phy_link_asserts
   import plt_pkg::*;
#(
   parameter int GAP_CYC = PLT_GAP_CYC_DEF
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // watched pins
   input wire logic [1:0] CONTROL_PAIR_I,
   input wire logic [1:0] CONTROL_PAIR_O,
   input wire logic [1:0] CONTROL_PAIR_OE,
   input wire logic [1:0] DATA_PAIR_I,
   input wire logic [1:0] DATA_PAIR_O,
   input wire logic RX_VALID,
   input wire logic [1:0] RX_PAIR,
   input wire logic RX_LAST,
   input wire logic RX_READY,
   input wire logic TX_VALID,
   input wire logic [1:0] TX_PAIR,
   input wire logic DATA_ON,
   input wire logic [1:0] BP_DRIVE_OE,
   input wire logic DRV_TOTEM
);
   // slack covers the registered control input
   localparam int RG_MAX = GAP_CYC + 6;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   // code v driven by the link or by the phy
   sequence s_lk(logic [1:0] v); CONTROL_PAIR_OE == 2'h0 && CONTROL_PAIR_I == v; endsequence
   sequence s_ph(logic [1:0] v); CONTROL_PAIR_OE == 2'h3 && CONTROL_PAIR_O == v; endsequence
   property p_grant; s_ph(2'h3) |=> s_ph(2'h0) ##1 CONTROL_PAIR_OE == 2'h0; endproperty
   a_grant: assert property (p_grant) else $error("grant");
   property p_rx_head; s_ph(2'h0) ##1 s_ph(2'h2) |-> DATA_PAIR_O == 2'h3 ##1 DATA_PAIR_O == 2'h0;
   endproperty
   a_rx_head: assert property (p_rx_head) else $error("rx head");
   property p_rx_pair; RX_VALID && RX_READY |=> s_ph(2'h2) ##0 DATA_PAIR_O == $past(RX_PAIR);
   endproperty
   a_rx_pair: assert property (p_rx_pair) else $error("rx pair");
   property p_rx_end; RX_VALID && RX_READY && RX_LAST |=> ##1 s_ph(2'h0); endproperty
   a_rx_end: assert property (p_rx_end) else $error("rx end");
   property p_hold; s_lk(2'h1)[*2] |=> DATA_ON; endproperty
   a_hold: assert property (p_hold) else $error("data on");
   property p_tx; s_lk(2'h2) |=> ##1 TX_VALID && TX_PAIR == $past(DATA_PAIR_I, 2); endproperty
   a_tx: assert property (p_tx) else $error("tx pair");
   property p_release; s_lk(2'h2) ##1 s_lk(2'h0)[*2] |-> ##[1:3] s_ph(2'h0); endproperty
   a_release: assert property (p_release) else $error("release");
   property p_regrant; s_lk(2'h2) ##1 s_lk(2'h1) ##1 s_lk(2'h0) |-> ##[2:RG_MAX] s_ph(2'h3);
   endproperty
   a_regrant: assert property (p_regrant) else $error("regrant");
   // every one bit of a sent pair is an asserted line, driven totem style
   property p_drive; TX_VALID |-> DRV_TOTEM && (BP_DRIVE_OE & TX_PAIR) == TX_PAIR; endproperty
   a_drive: assert property (p_drive) else $error("drive");
   property p_wired; s_ph(2'h3) |-> !DRV_TOTEM; endproperty
   a_wired: assert property (p_wired) else $error("wired or");
endmodule
bind plt_phy_link plt_phy_link_asserts #(.GAP_CYC(GAP_CYC)) i_plt_phy_link_asserts (
   .REF_CLK(REF_CLK), .RST_B(RST_B), .CONTROL_PAIR_I(CONTROL_PAIR_I),
   .CONTROL_PAIR_O(CONTROL_PAIR_O), .CONTROL_PAIR_OE(CONTROL_PAIR_OE),
   .DATA_PAIR_I(DATA_PAIR_I), .DATA_PAIR_O(DATA_PAIR_O), .RX_VALID(RX_VALID),
   .RX_PAIR(RX_PAIR), .RX_LAST(RX_LAST), .RX_READY(RX_READY), .TX_VALID(TX_VALID),
   .TX_PAIR(TX_PAIR), .DATA_ON(DATA_ON), .BP_DRIVE_OE(BP_DRIVE_OE), .DRV_TOTEM(DRV_TOTEM));

// ### verif/plt_phy_link_tb_top.sv
`timescale 1ns/1ps
// ========================================
// bench top: link model, random packets both ways
module plt_phy_link_tb_top;
   import plt_pkg::*;
   logic clk = 1'h0, rst_b = 1'h0, req = 1'h0, won = 1'h0, fast = 1'h0;
   logic rx_st = 1'h0, rx_v = 1'h0, rx_l = 1'h0, own, rdy, tv;
   logic [1:0] rx_p = 2'h0, co, coe, ci, d_o, doe, di, lctl, ldat, tp;
   int errors = 0, check_count = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   // wire level: phy, else link, else inverse of the link's last value
   assign ci = (coe & co) | (~coe & (own ? lctl : ~lctl));
   assign di = (doe & d_o) | (~doe & (own ? ldat : ~ldat));
   plt_phy_link #(.GAP_CYC(2)) i_plt_phy_link (.REF_CLK(clk), .RST_B(rst_b), .CE(1'h1),
      .LINK_REQUEST_LINE(req), .CONTROL_PAIR_I(ci), .CONTROL_PAIR_O(co), .CONTROL_PAIR_OE(coe),
      .DATA_PAIR_I(di), .DATA_PAIR_O(d_o), .DATA_PAIR_OE(doe), .ARB_WON(won), .SPEED_FAST(fast),
      .RX_START(rx_st), .RX_VALID(rx_v), .RX_PAIR(rx_p), .RX_LAST(rx_l), .RX_READY(rdy),
      .TX_VALID(tv), .TX_PAIR(tp), .BP_DRIVE_OE(), .DATA_ON(), .DRV_TOTEM());
   plt_link_model i_plt_link_model (.clk(clk), .ctl_o(co), .ctl_oe(coe), .own(own), .ctl(lctl),
      .dat(ldat));
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // each serial pair must be the next one the link sent
   // looked at mid-cycle, where the registered pair has settled
   always @(negedge clk)
      if (tv === 1'h1) check({2'h0, tp}, {2'h0, i_plt_link_model.sent.pop_front()});
   // one received packet, the data pair checked cycle by cycle
   task automatic rx_pkt(input int n);
      logic [1:0] p;
      rx_st = 1'h1;
      @(negedge clk);
      {rx_st, req, won} = 3'h0;
      check({co, d_o}, {PLT_CTL_RECEIVE, PLT_D_ALL_HIGH});
      @(negedge clk);
      check({co, d_o}, {PLT_CTL_RECEIVE, PLT_SPEED_CODE});
      for (int i = 1; i <= n; i++) begin
         for (int w = 0; w < 9 && rdy !== 1'h1; w++) @(negedge clk);
         check({3'h0, rdy}, 4'h1);
         p = 2'($urandom);
         {rx_v, rx_p, rx_l} = {1'h1, p, i == n};
         @(negedge clk);
         check({co, d_o}, {PLT_CTL_RECEIVE, p});
      end
      {rx_v, rx_l} = 2'h0;
      @(negedge clk);
      check({2'h0, co}, {2'h0, PLT_CTL_IDLE});
   endtask
   // odd passes end on hold and take a second grant without a request
   initial begin
      void'($urandom(8262));
      repeat (6) @(negedge clk);
      rst_b = 1'h1;
      repeat (2) @(negedge clk);
      for (int k = 0; k < 6; k++) begin
         fast = 1'($urandom);
         {req, won} = 2'h3;
         @(negedge clk);
         {req, won} = 2'h0;
         i_plt_link_model.own_bus($urandom % 4, 1 + $urandom % 6, k[0]);
         if (k[0]) i_plt_link_model.own_bus($urandom % 4, 1 + $urandom % 6, 1'h0);
         repeat (4) @(negedge clk);
         check(4'(i_plt_link_model.sent.size()), 4'h0);
         check({3'h0, i_plt_link_model.hung}, 4'h0);
      end
      for (int k = 0; k < 4; k++) begin
         {req, won} = {2{k == 0}};
         rx_pkt(1 + $urandom % 5);
      end
      print_verdict;
   end
endmodule
